// ==== include/lcd_defines.svh ====
// constants of the character display host port
`ifndef LCD_DEFINES_SVH
`define LCD_DEFINES_SVH

// ----------------------------------------
// clock and oscillator timing
// ----------------------------------------
`define CLK_KHZ        10000
`define OSC_KHZ        270
`define OSC_DIV        (`CLK_KHZ / `OSC_KHZ)
`define T_LONG_US      1530
`define T_SHORT_US     39
`define T_DATA_US      43
`define OSC_LONG       ((`T_LONG_US * `OSC_KHZ + 999) / 1000)
`define OSC_SHORT      ((`T_SHORT_US * `OSC_KHZ + 999) / 1000)
`define OSC_DATA       ((`T_DATA_US * `OSC_KHZ + 999) / 1000)

// ----------------------------------------
// memory and address layout
// ----------------------------------------
`define FILL_CODE      8'h20
`define HOME_ADDR      7'h00
`define LINE1_END      7'h27
`define LINE2_START    7'h40
`define LINE2_END      7'h67
`define ONE_LINE_END   7'h4F
`define TEXT_WORDS     128
`define GLYPH_WORDS    64
`define FILL_LAST      7'h7F

// ----------------------------------------
// instruction byte fields
// ----------------------------------------
`define BIT_TEXT_ADDR  7
`define BIT_GLYPH_ADDR 6
`define BIT_FUNC       5
`define BIT_SHIFT      4
`define BIT_DISP       3
`define BIT_ENTRY      2
`define BIT_HOME       1
`define BIT_CLEAR      0

// ----------------------------------------
// queue layout and reset values
// ----------------------------------------
`define QUEUE_DEPTH    4
`define ENTRY_W        10
`define RST_BUS8       1'b1
`define RST_INC        1'b1

`endif

// ==== include/lcd_pkg.sv ====
// types of the character display host port
package lcd_pkg;

  typedef enum logic [0:0] {
    EXEC_IDLE = 1'b0,
    EXEC_RUN  = 1'b1
  } exec_state_type;

  typedef struct packed {
    exec_state_type st;
    logic [6:0]     ac;
    logic           glyph;
    logic           inc;
    logic           scroll;
    logic           disp;
    logic           curs;
    logic           blink;
    logic           bus8;
    logic           two_line;
    logic           font;
    logic [6:0]     shift_off;
    logic [7:0]     rdata;
    logic [8:0]     busy_cnt;
    logic [5:0]     div;
    logic           clearing;
    logic [6:0]     fill;
    logic           phase;
    logic [3:0]     hold;
    logic           strobe_d;
    logic [7:0]     dout;
    logic           oe;
  } port_state_type;

endpackage

// ==== include/queue_if.sv ====
// valid/ready carrier between queue and its neighbours
`timescale 1ns/1ps
interface queue_if #(parameter int WIDTH = 10);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

// ==== hdl/pin_sync.sv ====
// two-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_type;

  sync_state_type state_reg;
  sync_state_type state_next;

  always_comb begin
    state_next        = state_reg;
    state_next.stage1 = d;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign q = state_reg.stage2;
endmodule

// ==== hdl/sync_queue.sv ====
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module sync_queue #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  input  wire logic clk,
  input  wire logic nrst,
  queue_if.sink     in_port,
  queue_if.source   out_port
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [PW:0]                 count;
  } queue_state_type;

  queue_state_type state_reg;
  queue_state_type state_next;
  logic            push;
  logic            pop;

  assign in_port.ready  = (state_reg.count != (PW+1)'(DEPTH));
  assign out_port.valid = (state_reg.count != '0);
  assign out_port.data  = state_reg.mem[state_reg.rd];
  assign push = in_port.valid && in_port.ready;
  assign pop  = out_port.valid && out_port.ready;

  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.mem[state_reg.wr] = in_port.data;
      state_next.wr = (state_reg.wr == PW'(DEPTH-1)) ? '0 : state_reg.wr + 1'b1;
    end
    if (pop) begin
      state_next.rd = (state_reg.rd == PW'(DEPTH-1)) ? '0 : state_reg.rd + 1'b1;
    end
    if (push && !pop) begin
      state_next.count = state_reg.count + 1'b1;
    end else if (pop && !push) begin
      state_next.count = state_reg.count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule

// ==== hdl/lcd_host_port.sv ====
// instruction decoder and host port of a character display controller
// Notes on behaviour
// RL1: data read returns byte of selected memory
// RL2: host sets address before first read
// RL3: text cursor shift reloads output data register
// RL4: address counter steps after each read
// RL5: host avoids display shift after glyph read
// RL6: write steps counter, output register keeps old
// RL7: clear fills text with 20H, counter zero
// RL8: home zeroes counter and display shift
// RL9: entry mode latches direction and scroll
// RL10: display control latches three on/off bits
// RL11: shift moves cursor or display, memory untouched
// RL12: function set latches width, lines, font
// RL13: glyph address set selects glyph memory
// RL14: text address set selects text memory
// RL15: status read gives busy flag and counter
// RL16: data write stores byte; transfers take 43us
// RL17: host waits half oscillator period after busy
// RL18: eight-bit mode moves byte per strobe
// RL19: four-bit mode uses upper lines only
// RL20: four-bit mode sends high nibble first
// RL21: four-bit busy starts after second nibble
// RL22: width select high means eight-bit bus
// RL23: busy flag reads one while executing
// RL24: two-line text addresses 00-27H and 40-67H
// RL25: busy times counted in oscillator ticks
// RL26: values latched on falling strobe edge
`timescale 1ns/1ps
`include "lcd_defines.svh"
module lcd_host_port (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       register_select,
  input  wire logic       read_write,
  input  wire logic       strobe,
  input  wire logic [7:0] host_data_lines,
  output logic      [7:0] host_data_out,
  output logic            host_data_oe,
  output logic            internal_activity_flag,
  output logic      [6:0] address_counter,
  output logic            glyph_selected,
  output logic            step_increment,
  output logic            whole_screen_scroll,
  output logic            display_on,
  output logic            cursor_on,
  output logic            blink_on,
  output logic            bus_width_select,
  output logic            two_line,
  output logic            font_tall,
  output logic      [6:0] shift_offset,
  output logic            queue_ready
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [10:0] pins_s;
  logic        rs_s;
  logic        rw_s;
  logic        strobe_s;
  logic [7:0]  bus_s;

  pin_sync #(.WIDTH(11)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    ({register_select, read_write, strobe, host_data_lines}),
    .q    (pins_s)
  );

  assign rs_s     = pins_s[10];
  assign rw_s     = pins_s[9];
  assign strobe_s = pins_s[8];
  assign bus_s    = pins_s[7:0];

  // ----------------------------------------
  // transfer queue
  // ----------------------------------------
  queue_if #(.WIDTH(`ENTRY_W)) push_if ();
  queue_if #(.WIDTH(`ENTRY_W)) pop_if ();

  sync_queue #(.WIDTH(`ENTRY_W), .DEPTH(`QUEUE_DEPTH)) u_queue (
    .clk      (clk),
    .nrst     (nrst),
    .in_port  (push_if.sink),
    .out_port (pop_if.source)
  );

  // ----------------------------------------
  // memories
  // ----------------------------------------
  logic [7:0] text_mem [0:`TEXT_WORDS-1];
  logic [7:0] glyph_mem [0:`GLYPH_WORDS-1];
  logic       text_we;
  logic       glyph_we;
  logic [6:0] mem_addr;
  logic [7:0] mem_wdata;

  always_ff @(posedge clk) begin
    if (text_we) begin
      text_mem[mem_addr] <= mem_wdata;
    end
    if (glyph_we) begin
      glyph_mem[mem_addr[5:0]] <= mem_wdata;
    end
  end

  // ----------------------------------------
  // address stepping
  // ----------------------------------------
  function automatic logic [6:0] step_addr(
    input logic [6:0] a,
    input logic       up,
    input logic       glyph,
    input logic       lines2
  );
    logic [6:0] r;
    r = up ? a + 7'h01 : a - 7'h01;
    if (glyph) begin
      r[6] = 1'b0;
    end else if (lines2) begin
      if (up && a == `LINE1_END) r = `LINE2_START; // RL24
      if (up && a == `LINE2_END) r = `HOME_ADDR; // RL24
      if (!up && a == `LINE2_START) r = `LINE1_END; // RL24
      if (!up && a == `HOME_ADDR) r = `LINE2_END; // RL24
    end else begin
      if (up && a == `ONE_LINE_END) r = `HOME_ADDR;
      if (!up && a == `HOME_ADDR) r = `ONE_LINE_END;
    end
    return r;
  endfunction

  // ----------------------------------------
  // state and next state
  // ----------------------------------------
  lcd_pkg::port_state_type state_reg;
  lcd_pkg::port_state_type state_next;
  logic       busy;
  logic       fall;
  logic       rise;
  logic       byte_done;
  logic [7:0] full_byte;
  logic [7:0] sel_byte;
  logic       h_rs;
  logic       h_rw;
  logic [7:0] h_b;
  logic [6:0] nxt_ac;
  logic       tick;

  assign busy = (state_reg.st != lcd_pkg::EXEC_IDLE) || pop_if.valid; // RL23
  assign fall = state_reg.strobe_d && !strobe_s;
  assign rise = !state_reg.strobe_d && strobe_s;
  assign tick = (state_reg.div == 6'(`OSC_DIV - 1));
  assign {h_rs, h_rw, h_b} = pop_if.data;

  // four-bit mode assembles the high nibble first
  assign full_byte = state_reg.bus8 ? bus_s : {state_reg.hold, bus_s[7:4]}; // RL19 RL20
  assign byte_done = state_reg.bus8 || state_reg.phase; // RL18 RL21 RL22

  // push completed transfers except status reads
  assign push_if.valid = fall && byte_done && !(!rs_s && rw_s); // RL26
  assign push_if.data  = {rs_s, rw_s, rw_s ? 8'h00 : full_byte};
  assign pop_if.ready  = (state_reg.st == lcd_pkg::EXEC_IDLE);
  assign sel_byte = rs_s ? state_reg.rdata : {busy, state_reg.ac}; // RL1 RL15

  always_comb begin
    state_next = state_reg;
    text_we    = 1'b0;
    glyph_we   = 1'b0;
    mem_addr   = state_reg.ac;
    mem_wdata  = h_b;
    nxt_ac     = step_addr(state_reg.ac, state_reg.inc, state_reg.glyph, state_reg.two_line);

    // oscillator tick divider
    state_next.div = tick ? 6'h00 : state_reg.div + 6'h01;

    // host strobe edges
    state_next.strobe_d = strobe_s;
    if (rise) begin
      state_next.oe = rw_s;
    end
    if (fall) begin
      state_next.oe = 1'b0;
      if (!state_reg.bus8) begin
        state_next.phase = !state_reg.phase; // RL20
        if (!state_reg.phase) begin
          state_next.hold = bus_s[7:4]; // RL19
        end
      end
    end

    // read data presented on the lines
    if (state_reg.bus8) begin
      state_next.dout = sel_byte; // RL18
    end else if (!state_reg.phase) begin
      state_next.dout = {sel_byte[7:4], 4'h0}; // RL20
    end else begin
      state_next.dout = {sel_byte[3:0], 4'h0}; // RL20
    end

    // text fill sweep of clear
    if (state_reg.clearing) begin
      text_we   = 1'b1;
      mem_addr  = state_reg.fill;
      mem_wdata = `FILL_CODE; // RL7
      state_next.fill = state_reg.fill + 7'h01;
      if (state_reg.fill == `FILL_LAST) begin
        state_next.clearing = 1'b0;
      end
    end

    case (state_reg.st)
      lcd_pkg::EXEC_IDLE: begin
        if (pop_if.valid) begin
          state_next.st       = lcd_pkg::EXEC_RUN;
          state_next.busy_cnt = 9'(`OSC_SHORT); // RL25
          if (h_rs) begin
            state_next.busy_cnt = 9'(`OSC_DATA); // RL16 RL25
            state_next.ac       = nxt_ac; // RL4 RL6
            if (!h_rw) begin
              text_we  = !state_reg.glyph; // RL16
              glyph_we = state_reg.glyph; // RL16
              if (!state_reg.glyph && state_reg.scroll) begin
                state_next.shift_off = state_reg.inc ? state_reg.shift_off + 7'h01
                                                     : state_reg.shift_off - 7'h01;
              end
            end else begin
              state_next.rdata = state_reg.glyph ? glyph_mem[nxt_ac[5:0]]
                                                 : text_mem[nxt_ac]; // RL1 RL4
            end
          end else if (h_b[`BIT_TEXT_ADDR]) begin
            state_next.ac    = h_b[6:0]; // RL14
            state_next.glyph = 1'b0; // RL14
            state_next.rdata = text_mem[h_b[6:0]]; // RL1
          end else if (h_b[`BIT_GLYPH_ADDR]) begin
            state_next.ac    = {1'b0, h_b[5:0]}; // RL13
            state_next.glyph = 1'b1; // RL13
            state_next.rdata = glyph_mem[h_b[5:0]]; // RL1
          end else if (h_b[`BIT_FUNC]) begin
            state_next.bus8     = h_b[4]; // RL12 RL22
            state_next.two_line = h_b[3]; // RL12
            state_next.font     = h_b[2]; // RL12
            state_next.phase    = 1'b0;
          end else if (h_b[`BIT_SHIFT]) begin
            if (h_b[3]) begin
              state_next.shift_off = h_b[2] ? state_reg.shift_off - 7'h01
                                            : state_reg.shift_off + 7'h01; // RL11
            end else begin
              state_next.ac = step_addr(state_reg.ac, h_b[2], state_reg.glyph,
                                        state_reg.two_line); // RL11
              if (!state_reg.glyph) begin
                state_next.rdata = text_mem[step_addr(state_reg.ac, h_b[2], 1'b0,
                                                      state_reg.two_line)]; // RL3
              end
            end
          end else if (h_b[`BIT_DISP]) begin
            state_next.disp  = h_b[2]; // RL10
            state_next.curs  = h_b[1]; // RL10
            state_next.blink = h_b[0]; // RL10
          end else if (h_b[`BIT_ENTRY]) begin
            state_next.inc    = h_b[1]; // RL9
            state_next.scroll = h_b[0]; // RL9
          end else if (h_b[`BIT_HOME]) begin
            state_next.ac        = `HOME_ADDR; // RL8
            state_next.glyph     = 1'b0;
            state_next.shift_off = 7'h00; // RL8
            state_next.busy_cnt  = 9'(`OSC_LONG); // RL8 RL25
          end else if (h_b[`BIT_CLEAR]) begin
            state_next.ac        = `HOME_ADDR; // RL7
            state_next.glyph     = 1'b0;
            state_next.inc       = 1'b1;
            state_next.shift_off = 7'h00;
            state_next.clearing  = 1'b1; // RL7
            state_next.fill      = 7'h00;
            state_next.busy_cnt  = 9'(`OSC_LONG); // RL7 RL25
          end
        end
      end
      lcd_pkg::EXEC_RUN: begin
        if (tick) begin
          state_next.busy_cnt = state_reg.busy_cnt - 9'h001; // RL25
          if (state_reg.busy_cnt == 9'h001 && !state_reg.clearing) begin
            state_next.st = lcd_pkg::EXEC_IDLE; // RL23
          end
        end
        if (state_reg.busy_cnt == 9'h000) begin
          state_next.busy_cnt = 9'h000;
          if (!state_reg.clearing) begin
            state_next.st = lcd_pkg::EXEC_IDLE;
          end
        end
      end
      default: begin
        state_next.st = lcd_pkg::EXEC_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg      <= '0;
      state_reg.bus8 <= `RST_BUS8;
      state_reg.inc  <= `RST_INC;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign host_data_out          = state_reg.dout;
  assign host_data_oe           = state_reg.oe; // RL15
  assign internal_activity_flag = busy; // RL23
  assign address_counter        = state_reg.ac;
  assign glyph_selected         = state_reg.glyph;
  assign step_increment         = state_reg.inc;
  assign whole_screen_scroll    = state_reg.scroll;
  assign display_on             = state_reg.disp;
  assign cursor_on              = state_reg.curs;
  assign blink_on               = state_reg.blink;
  assign bus_width_select       = state_reg.bus8;
  assign two_line               = state_reg.two_line;
  assign font_tall              = state_reg.font;
  assign shift_offset           = state_reg.shift_off;
  assign queue_ready            = push_if.ready;
endmodule

// ==== bench/lcd_host_port_props.sv ====
// concurrent checks on the ports of the character display host port
`timescale 1ns/1ps
module lcd_host_port_props (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       read_write,
  input wire logic       strobe,
  input wire logic [7:0] host_data_out,
  input wire logic       host_data_oe,
  input wire logic       internal_activity_flag,
  input wire logic [6:0] address_counter,
  input wire logic       display_on,
  input wire logic       cursor_on,
  input wire logic       blink_on,
  input wire logic       bus_width_select,
  input wire logic       two_line,
  input wire logic       whole_screen_scroll,
  input wire logic [6:0] shift_offset,
  input wire logic       queue_ready
);
  // ----------------------------------------
  // busy length counter and properties
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  logic [15:0] busy_len;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_len <= 16'h0000;
    end else begin
      busy_len <= internal_activity_flag ? busy_len + 16'h0001 : 16'h0000;
    end
  end
  AST_OE_ONLY_READ: assert property (
    host_data_oe |-> read_write) else $error("data driven outside a read");
  AST_OE_AFTER_STROBE: assert property (
    $rose(host_data_oe) |-> strobe && $past(strobe)) else $error("drive without strobe");
  AST_NIBBLE_LOW_ZERO: assert property (
    host_data_oe && !bus_width_select |-> host_data_out[3:0] == 4'h0)
    else $error("low lines not zero in narrow mode");
  AST_FULL_MEANS_BUSY: assert property (
    !queue_ready |-> internal_activity_flag) else $error("full queue but idle");
  AST_SHIFT_KEEPS_COUNT: assert property (
    $changed(shift_offset) && shift_offset != 7'h00 && !whole_screen_scroll
    |-> $stable(address_counter))
    else $error("display shift moved counter");
  AST_BUSY_MIN: assert property (
    $rose(internal_activity_flag) |=> internal_activity_flag [*8])
    else $error("busy too short");
  AST_BUSY_MAX: assert property (
    busy_len < 16'h4268) else $error("busy too long");
  AST_CONFIG_WHILE_BUSY: assert property (
    $changed({display_on, cursor_on, blink_on, two_line, bus_width_select})
    |-> internal_activity_flag) else $error("config changed while idle");
endmodule
bind lcd_host_port lcd_host_port_props props (.*);

// ==== bench/lcd_host_model.sv ====
// host processor model driving the strobed parallel bus
`timescale 1ns/1ps
module lcd_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] host_data_out,
  output logic            register_select,
  output logic            read_write,
  output logic            strobe,
  output logic      [7:0] host_data_lines
);
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  logic bus8;
  initial begin
    bus8 = 1'b1;
    register_select = 1'b0;
    read_write = 1'b1;
    strobe = 1'b0;
    host_data_lines = 8'hFF;
  end
  task automatic edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input logic rs, input logic rw, input logic [7:0] d,
                       output logic [7:0] q);
    edges(1);
    register_select = rs;
    read_write = rw;
    host_data_lines = rw ? ~host_data_lines : d;
    edges(1);
    strobe = 1'b1;
    edges(6);
    q = host_data_out;
    strobe = 1'b0;
    edges(6);
    host_data_lines = ~host_data_lines;
  endtask
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
                      output logic [7:0] q);
    logic [7:0] hi;
    logic [7:0] lo;
    if (bus8) begin
      pulse(rs, rw, d, q);
    end else begin
      pulse(rs, rw, {d[7:4], ~d[3:0]}, hi);
      pulse(rs, rw, {d[3:0], d[7:4]}, lo);
      q = {hi[7:4], lo[7:4]};
    end
  endtask
  task automatic wait_idle(output logic [7:0] st);
    int n;
    n = 0;
    xfer(1'b0, 1'b1, 8'h00, st);
    while (st[7] !== 1'b0 && n < 2000) begin
      xfer(1'b0, 1'b1, 8'h00, st);
      n++;
    end
    edges(20);
  endtask
endmodule

// ==== bench/lcd_host_port_tb_top.sv ====
// self-checking testbench of the character display host port
`timescale 1ns/1ps
`define CHECK(what, exp, got) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("wrong value %s expected %0h seen %0h", what, exp, got); \
  end \
end
module lcd_host_port_tb_top;
  // ----------------------------------------
  // signals, instances and tasks
  // ----------------------------------------
  logic       clk;
  logic       nrst;
  logic       register_select;
  logic       read_write;
  logic       strobe;
  logic [7:0] host_data_lines;
  logic [7:0] host_data_out;
  logic       host_data_oe;
  logic       internal_activity_flag;
  logic [6:0] address_counter;
  logic       glyph_selected;
  logic       step_increment;
  logic       whole_screen_scroll;
  logic       display_on;
  logic       cursor_on;
  logic       blink_on;
  logic       bus_width_select;
  logic       two_line;
  logic       font_tall;
  logic [6:0] shift_offset;
  logic       queue_ready;
  logic [7:0] q;
  logic       full_seen;
  int         fails;
  int         tests_run;
  initial clk = 1'b0;
  always #50 clk = ~clk;
  lcd_host_port dut (.*);
  lcd_host_model host (.*);
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic idle;
    host.wait_idle(q);
    `CHECK("busy flag", 1'b0, q[7])
  endtask
  task automatic cmd(input logic [7:0] c, input logic b8);
    host.xfer(1'b0, 1'b0, c, q);
    host.bus8 = b8;
    host.xfer(1'b0, 1'b1, 8'h00, q);
    `CHECK("busy at start", 1'b1, q[7])
    idle();
  endtask
  task automatic wr(input logic [7:0] d);
    host.xfer(1'b1, 1'b0, d, q);
    idle();
  endtask
  task automatic rd(input logic [7:0] exp);
    logic [7:0] r;
    host.xfer(1'b1, 1'b1, 8'h00, r);
    `CHECK("read data", exp, r)
    idle();
  endtask
  initial begin
    #9000000;
    fails++;
    test_done();
  end
  initial begin
    fails = 0;
    tests_run = 0;
    full_seen = 1'b0;
    nrst = 1'b0;
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    `CHECK("width reset", 1'b1, bus_width_select)
    `CHECK("step reset", 1'b1, step_increment)
    `CHECK("counter reset", 7'h00, address_counter)
    cmd(8'h38, 1'b1);
    `CHECK("width", 1'b1, bus_width_select)
    `CHECK("lines", 1'b1, two_line)
    `CHECK("font", 1'b0, font_tall)
    for (int i = 0; i < 8; i++) begin
      cmd(8'h08 | i[7:0], 1'b1);
      `CHECK("display bits", i[2:0], {display_on, cursor_on, blink_on})
    end
    for (int i = 0; i < 4; i++) begin
      cmd(8'h04 | i[7:0], 1'b1);
      `CHECK("entry bits", i[1:0], {step_increment, whole_screen_scroll})
    end
    cmd(8'h04, 1'b1);
    cmd(8'h01, 1'b1);
    `CHECK("clear counter", 7'h00, address_counter)
    `CHECK("clear step", 1'b1, step_increment)
    cmd(8'h80, 1'b1);
    rd(8'h20);
    cmd(8'hE7, 1'b1);
    rd(8'h20);
    cmd(8'hC0, 1'b1);
    `CHECK("text address", 7'h40, address_counter)
    `CHECK("text select", 1'b0, glyph_selected)
    wr(8'hA5);
    wr(8'h5A);
    `CHECK("write step", 7'h42, address_counter)
    cmd(8'hC0, 1'b1);
    rd(8'hA5);
    `CHECK("read step", 7'h41, address_counter)
    rd(8'h5A);
    cmd(8'h04, 1'b1);
    cmd(8'hC1, 1'b1);
    rd(8'h5A);
    `CHECK("read down", 7'h40, address_counter)
    cmd(8'h06, 1'b1);
    cmd(8'hC0, 1'b1);
    wr(8'h3C);
    rd(8'hA5);
    cmd(8'hC0, 1'b1);
    cmd(8'h14, 1'b1);
    `CHECK("cursor shift", 7'h41, address_counter)
    rd(8'h5A);
    cmd(8'h18, 1'b1);
    `CHECK("display shift", 7'h01, shift_offset)
    `CHECK("shift keeps counter", 7'h42, address_counter)
    cmd(8'h02, 1'b1);
    `CHECK("home counter", 7'h00, address_counter)
    `CHECK("home shift", 7'h00, shift_offset)
    cmd(8'hC0, 1'b1);
    rd(8'h3C);
    cmd(8'h07, 1'b1);
    wr(8'h77);
    `CHECK("scroll on write", 7'h01, shift_offset)
    `CHECK("scroll write step", 7'h42, address_counter)
    cmd(8'h06, 1'b1);
    cmd(8'h45, 1'b1);
    `CHECK("glyph address", 7'h05, address_counter)
    `CHECK("glyph select", 1'b1, glyph_selected)
    wr(8'h1F);
    cmd(8'h45, 1'b1);
    rd(8'h1F);
    cmd(8'h28, 1'b0);
    `CHECK("narrow width", 1'b0, bus_width_select)
    host.pulse(1'b0, 1'b0, 8'h0A, q);
    `CHECK("busy first nibble", 1'b0, internal_activity_flag)
    host.pulse(1'b0, 1'b0, 8'hC5, q);
    `CHECK("busy second nibble", 1'b1, internal_activity_flag)
    idle();
    `CHECK("nibble display", 3'b100, {display_on, cursor_on, blink_on})
    cmd(8'hC0, 1'b0);
    rd(8'h3C);
    cmd(8'h38, 1'b1);
    `CHECK("wide again", 1'b1, bus_width_select)
    cmd(8'h80, 1'b1);
    for (int i = 0; i < 6; i++) begin
      host.xfer(1'b1, 1'b0, 8'h41 + i[7:0], q);
      full_seen = full_seen | ~queue_ready;
    end
    `CHECK("queue refused", 1'b1, full_seen)
    idle();
    `CHECK("queue drained", 1'b1, queue_ready)
    `CHECK("writes kept", 7'h05, address_counter)
    test_done();
  end
endmodule
